/* File: rtl/smx_map.svh */
`ifndef SMX_MAP_SVH
`define SMX_MAP_SVH

// Frame and status geometry
`define SMX_WORD_BITS       24
`define SMX_SW_COUNT        22
`define SMX_CNT_BITS        5

// Core clock rate and timer counter width
`define SMX_CLK_MHZ         250
`define SMX_TMR_BITS        24

// Wetting pulse, nominal figure in microseconds
`define SMX_WET_PULSE_US    16000
`define SMX_WET_PULSE_CYC   (`SMX_WET_PULSE_US * `SMX_CLK_MHZ)

// Sleep scan on-time, nominal figure in microseconds
`define SMX_SCAN_ON_US      200
`define SMX_SCAN_ON_CYC     (`SMX_SCAN_ON_US * `SMX_CLK_MHZ)

// Programmed sleep timer periods, plain defaults in microseconds
`define SMX_SCAN_PERIOD_US  64000
`define SMX_SCAN_PERIOD_CYC (`SMX_SCAN_PERIOD_US * `SMX_CLK_MHZ)
`define SMX_INT_PERIOD_US   32000
`define SMX_INT_PERIOD_CYC  (`SMX_INT_PERIOD_US * `SMX_CLK_MHZ)

`endif

/* File: rtl/smx_pkg.sv */
`include "smx_map.svh"

package smx_pkg;

    typedef logic [`SMX_WORD_BITS-1:0] smx_word_t;
    typedef logic [`SMX_SW_COUNT-1:0]  smx_sw_t;
    typedef logic [`SMX_CNT_BITS-1:0]  smx_cnt_t;
    typedef logic [`SMX_TMR_BITS-1:0]  smx_tmr_t;

    // Response word: interrupt flag in the MSB, thermal flag next, switches below
    typedef struct packed {
        logic    int_flag;
        logic    therm;
        smx_sw_t sw;
    } smx_status_t;

    typedef struct packed {
        smx_word_t word;
        logic      valid;
    } smx_cmd_t;

    typedef enum logic {
        SMX_ST_IDLE,
        SMX_ST_FRAME
    } smx_fstate_t;

    typedef struct packed {
        smx_fstate_t st;
        logic        so_oe_n;
        logic        int_oe_n;
        logic        pend;
        smx_sw_t     ref_sw;
        smx_status_t snap;
        smx_cmd_t    cmd;
        logic        wake;
    } smx_sys_t;

    typedef struct packed {
        smx_word_t sr;
        smx_cnt_t  cnt;
        logic      full;
    } smx_rx_t;

    typedef struct packed {
        smx_tmr_t cnt;
        logic     busy;
        logic     done;
    } smx_tmr_st_t;

endpackage : smx_pkg

/* File: rtl/smx_spi_slave.sv */
`timescale 1ns/1ns
`include "smx_map.svh"

// What this block and its host do
// R1: Chip select low frames command in, status out
// R2: Select fall enables output, snapshots interrupt, switches
// R3: Select rise floats the serial output
// R4: Select rise clears interrupt unless newer changes
// R5: Command commits only at select rise
// R6: Host moves select only while clock low
// R7: Select fall during sleep requests wake
// R8: Host distrusts status read during wake frame
// R9: Input bit sampled on clock falling edge
// R10: Output changes on clock rising edge
// R11: Select high ignores clock, input; output floats
// R12: Host should park clock low when idle
// R13: Command word is exactly 24 bits
// R14: Closed switch reads one, open reads zero
// R15: First rising edge presents status MSB
// R16: MSB first, input to output first-in first-out
// R17: Wetting pulse lasts fifteen to twenty milliseconds
// R18: Sleep scan keeps inputs on 100-300 us
// R19: Scan timer within ten percent of programmed
// R20: Interrupt timer within ten percent of programmed
// R21: Every response carries switches, interrupt, thermal flag
// R22: Two chained devices need 48 clocks
// R23: Shift register on serial clock, commit synchronised
module smx_spi_slave
    import smx_pkg::*;
#(
    parameter int unsigned WET_CYC         = `SMX_WET_PULSE_CYC,
    parameter int unsigned SCAN_ON_CYC     = `SMX_SCAN_ON_CYC,
    parameter int unsigned SCAN_PERIOD_CYC = `SMX_SCAN_PERIOD_CYC,
    parameter int unsigned INT_PERIOD_CYC  = `SMX_INT_PERIOD_CYC
) (
    // Core clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    // Serial link
    input  wire logic             i_sclk,
    input  wire logic             i_cs_n,
    input  wire logic             i_si,
    output logic                  o_so,
    output logic                  o_so_oe_n,
    // Open-drain interrupt pin
    input  wire logic             i_int_in,
    output logic                  o_int_out,
    output logic                  o_int_oe_n,
    // Switch front end and mode
    input  wire smx_pkg::smx_sw_t i_sw_closed,
    input  wire logic             i_therm,
    input  wire logic             i_int_en,
    input  wire logic             i_sleep,
    // Results
    output smx_pkg::smx_cmd_t     o_cmd,
    output logic                  o_wake,
    output logic                  o_wet_pulse,
    output logic                  o_scan_active,
    output logic                  o_int_timer_exp
);

    import smx_pkg::*;

    localparam int unsigned SYNC_W = `SMX_SW_COUNT + 2;

    smx_sys_t    sys_reg;
    smx_sys_t    sys_next;
    smx_rx_t     rx_reg;
    smx_rx_t     rx_next;
    logic        rx_loaded_reg;
    logic        so_reg;
    logic        so_next;
    logic        frame_rst_n;
    logic        cs_f;
    logic        int_in_f;
    logic        therm_f;
    smx_sw_t     sw_f;
    logic        cs_fall;
    logic        cs_rise;
    logic        change;
    logic        word_whole;
    logic        per_busy;
    logic        per_done;
    logic        int_busy;
    logic        int_done;

    function automatic logic word_done(input smx_cnt_t cnt, input logic full);
        word_done = full && (cnt == '0);
    endfunction : word_done

    // Pin levels cross into the core domain
    smx_sync #(
        .W (1)
    ) u_cs_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_d     (i_cs_n),
        .o_q     (cs_f)
    );

    smx_sync #(
        .W (SYNC_W)
    ) u_pin_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_d     ({i_int_in, i_therm, i_sw_closed}),
        .o_q     ({int_in_f, therm_f, sw_f})
    );

    // Reset leaves the synchronised select low, so a frame is only
    // seen once the synchronised select has been high first
    logic cs_seen_high_reg;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cs_seen_high_reg <= 1'b0;
        end else if (cs_f) begin
            cs_seen_high_reg <= 1'b1;
        end
    end

    assign cs_fall    = cs_seen_high_reg && (sys_reg.st == SMX_ST_IDLE) && !cs_f;
    assign cs_rise    = (sys_reg.st == SMX_ST_FRAME) && cs_f;
    assign change     = i_int_en && (sw_f != sys_reg.ref_sw);
    assign word_whole = word_done(rx_reg.cnt, rx_reg.full);

    always_comb begin
        sys_next           = sys_reg;
        sys_next.wake      = 1'b0;
        sys_next.cmd.valid = 1'b0;
        if (change) begin
            sys_next.ref_sw   = sw_f;
            sys_next.int_oe_n = 1'b0;
            if (sys_reg.st == SMX_ST_FRAME) begin
                sys_next.pend = 1'b1;                           // see R4
            end
        end
        case (sys_reg.st)
            SMX_ST_IDLE: begin
                if (cs_fall) begin                              // see R1
                    sys_next.st            = SMX_ST_FRAME;
                    sys_next.so_oe_n       = 1'b0;              // see R2
                    sys_next.snap.int_flag = !int_in_f;         // see R2 R21
                    sys_next.snap.therm    = therm_f;           // see R21
                    sys_next.snap.sw       = sw_f;              // see R14
                    sys_next.ref_sw        = sw_f;
                    sys_next.pend          = 1'b0;
                    sys_next.wake          = i_sleep;           // see R7
                end
            end
            SMX_ST_FRAME: begin
                if (cs_rise) begin
                    sys_next.st       = SMX_ST_IDLE;
                    sys_next.so_oe_n  = 1'b1;                   // see R3
                    // A change in the rise cycle keeps the pin low too
                    sys_next.int_oe_n = !(sys_reg.pend || change); // see R4
                    sys_next.pend     = 1'b0;
                    sys_next.ref_sw   = sw_f;                   // see R4
                    // The word is stable since the last clock fall, so
                    // the select rise acts as the crossing handshake
                    if (word_whole) begin                       // see R13 R23
                        sys_next.cmd.word  = rx_reg.sr;         // see R5
                        sys_next.cmd.valid = 1'b1;
                    end
                end
            end
            default: begin
                sys_next.st = SMX_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sys_reg          <= '0;
            sys_reg.st       <= SMX_ST_IDLE;
            sys_reg.so_oe_n  <= 1'b1;
            sys_reg.int_oe_n <= 1'b1;
        end else begin
            sys_reg <= sys_next;
        end
    end

    // Link side: select high holds the frame logic in reset
    assign frame_rst_n = i_rst_n && !i_cs_n;                    // see R11

    // The snapshot is stable well before the first clock rise
    always_comb begin
        rx_next = rx_reg;
        if (!i_cs_n) begin                                      // see R6
            if (!rx_loaded_reg) begin
                rx_next.sr   = {sys_reg.snap[`SMX_WORD_BITS-2:0], i_si}; // see R9 R16
                rx_next.cnt  = `SMX_CNT_BITS'(1);
                rx_next.full = 1'b0;
            end else begin
                rx_next.sr = {rx_reg.sr[`SMX_WORD_BITS-2:0], i_si}; // see R9 R16 R22
                if (rx_reg.cnt == `SMX_CNT_BITS'(`SMX_WORD_BITS - 1)) begin
                    rx_next.cnt  = '0;
                    rx_next.full = 1'b1;                        // see R13
                end else begin
                    rx_next.cnt = rx_reg.cnt + 1'b1;
                end
            end
        end
    end

    always_ff @(negedge i_sclk or negedge i_rst_n) begin        // see R23
        if (!i_rst_n) begin
            rx_reg <= '0;
        end else begin
            rx_reg <= rx_next;
        end
    end

    always_ff @(negedge i_sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            rx_loaded_reg <= 1'b0;
        end else begin
            rx_loaded_reg <= 1'b1;
        end
    end

    // First rise shows the snapshot MSB, later rises the shifted word
    always_comb begin
        so_next = rx_loaded_reg ? rx_reg.sr[`SMX_WORD_BITS-1]
                                : sys_reg.snap[`SMX_WORD_BITS-1]; // see R15 R16
    end

    always_ff @(posedge i_sclk or negedge frame_rst_n) begin    // see R10
        if (!frame_rst_n) begin
            so_reg <= 1'b0;
        end else begin
            so_reg <= so_next;
        end
    end

    // Timers
    smx_timer #(
        .CYC (WET_CYC)
    ) u_wet (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_start (change),                                      // see R17
        .o_busy  (o_wet_pulse),
        .o_done  ()
    );

    smx_timer #(
        .CYC (SCAN_PERIOD_CYC)
    ) u_scan_period (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_start (i_sleep && !per_busy),                        // see R19
        .o_busy  (per_busy),
        .o_done  (per_done)
    );

    smx_timer #(
        .CYC (SCAN_ON_CYC)
    ) u_scan_on (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_start (i_sleep && per_done),                         // see R18
        .o_busy  (o_scan_active),
        .o_done  ()
    );

    smx_timer #(
        .CYC (INT_PERIOD_CYC)
    ) u_int_period (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_start (i_sleep && !int_busy),                        // see R20
        .o_busy  (int_busy),
        .o_done  (int_done)
    );

    assign o_int_timer_exp = int_done;
    assign o_so            = so_reg;
    assign o_so_oe_n       = sys_reg.so_oe_n;
    assign o_int_out       = 1'b0;
    assign o_int_oe_n      = sys_reg.int_oe_n;
    assign o_cmd           = sys_reg.cmd;
    assign o_wake          = sys_reg.wake;

    // Checks
    AST_SO_ENABLE: assert property ( // see R2
        @(posedge i_clk) disable iff (!i_rst_n)
        cs_fall |=> !o_so_oe_n && sys_reg.st == SMX_ST_FRAME
    ) else $error("output not enabled after select fall");

    AST_SO_RELEASE: assert property ( // see R3
        @(posedge i_clk) disable iff (!i_rst_n)
        cs_rise |=> o_so_oe_n
    ) else $error("output not released after select rise");

    AST_SO_FLOAT_IDLE: assert property ( // see R11
        @(posedge i_clk) disable iff (!i_rst_n)
        (sys_reg.st == SMX_ST_IDLE && !cs_fall) |=> o_so_oe_n
    ) else $error("output driven outside a frame");

    AST_INT_CLEAR: assert property ( // see R4
        @(posedge i_clk) disable iff (!i_rst_n)
        cs_rise && !sys_reg.pend && !change |=> o_int_oe_n
    ) else $error("interrupt not cleared at select rise");

    AST_INT_HOLD: assert property ( // see R4
        @(posedge i_clk) disable iff (!i_rst_n)
        cs_rise && sys_reg.pend |=> !o_int_oe_n ##1 !o_int_oe_n
    ) else $error("interrupt dropped despite changes in frame");

    AST_SNAPSHOT: assert property ( // see R2
        @(posedge i_clk) disable iff (!i_rst_n)
        cs_fall |=> sys_reg.snap.sw == $past(sw_f)
                    && sys_reg.snap.int_flag == !$past(int_in_f)
    ) else $error("snapshot does not match switch state");

    AST_CMD_COMMIT: assert property ( // see R5
        @(posedge i_clk) disable iff (!i_rst_n)
        cs_rise && word_whole |=> o_cmd.valid && o_cmd.word == $past(rx_reg.sr)
    ) else $error("whole word not committed at select rise");

    AST_CMD_ONLY_AT_RISE: assert property ( // see R13
        @(posedge i_clk) disable iff (!i_rst_n)
        o_cmd.valid |-> $past(cs_rise) && $past(word_whole)
    ) else $error("command committed outside select rise");

    AST_WAKE: assert property ( // see R7
        @(posedge i_clk) disable iff (!i_rst_n)
        cs_fall && i_sleep |=> o_wake ##1 !o_wake
    ) else $error("wake pulse missing or too long");

    AST_WET_PULSE: assert property ( // see R17
        @(posedge i_clk) disable iff (!i_rst_n)
        change |=> o_wet_pulse [*8]
    ) else $error("wetting pulse ended early");

    AST_RX_SHIFT: assert property ( // see R9
        @(negedge i_sclk) disable iff (!frame_rst_n)
        rx_loaded_reg |=> rx_reg.sr[0] == $past(i_si)
                          && rx_reg.sr[1] == $past(rx_reg.sr[0])
    ) else $error("input bit not shifted in");

    AST_SO_FIRST: assert property ( // see R15
        @(posedge i_sclk) disable iff (!frame_rst_n)
        !rx_loaded_reg && !$past(rx_loaded_reg) |-> so_next == sys_reg.snap.int_flag
    ) else $error("first output bit is not status MSB");

    COV_FRAME: cover property (
        @(posedge i_clk) disable iff (!i_rst_n) cs_fall ##[1:1000] cs_rise
    );

    COV_COMMIT: cover property (
        @(posedge i_clk) disable iff (!i_rst_n) o_cmd.valid
    );

    COV_INT_HOLD: cover property (
        @(posedge i_clk) disable iff (!i_rst_n) cs_rise && sys_reg.pend
    );

    COV_WAKE: cover property (
        @(posedge i_clk) disable iff (!i_rst_n) o_wake
    );

endmodule : smx_spi_slave

/* File: rtl/smx_sync.sv */
`timescale 1ns/1ns

module smx_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    // Asynchronous level in, filtered level out
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } smx_sync_st_t;

    smx_sync_st_t st_reg;
    smx_sync_st_t st_next;
    logic [W-1:0] q_next;

    genvar g;

    // A bit moves once stages two and three agree
    for (g = 0; g < W; g++) begin : g_bit
        assign q_next[g] = (st_reg.s2[g] == st_reg.s3[g]) ? st_reg.s3[g] : st_reg.q[g];
    end

    // Stage one feeds only stage two
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = i_d;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        st_next.q  = q_next;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_q = st_reg.q;

endmodule : smx_sync

/* File: rtl/smx_timer.sv */
`timescale 1ns/1ns
`include "smx_map.svh"

module smx_timer
    import smx_pkg::*;
#(
    parameter int unsigned CYC = 1
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // Start or restart; busy for CYC cycles, then one done pulse
    input  wire logic i_start,
    output logic      o_busy,
    output logic      o_done
);

    smx_tmr_st_t t_reg;
    smx_tmr_st_t t_next;

    // A digital count is exact, so a programmed period never drifts
    always_comb begin
        t_next      = t_reg;
        t_next.done = 1'b0;
        if (i_start) begin
            t_next.cnt  = `SMX_TMR_BITS'(CYC - 1);
            t_next.busy = 1'b1;
        end else if (t_reg.busy) begin
            if (t_reg.cnt == '0) begin
                t_next.busy = 1'b0;
                t_next.done = 1'b1;
            end else begin
                t_next.cnt = t_reg.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            t_reg <= '0;
        end else begin
            t_reg <= t_next;
        end
    end

    assign o_busy = t_reg.busy;
    assign o_done = t_reg.done;

endmodule : smx_timer

/* File: tb/smx_host.sv */
`timescale 1ns/1ns

module smx_host (
    // Link lines driven by the host
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_si,
    // Device answer
    input  wire logic i_so,
    input  wire logic i_so_oe_n
);
    logic oe_ok;

    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_si   = 1'b0;
        oe_ok  = 1'b1;
    end

    // One framed transfer of n bits, MSB first; clock runs only inside the frame
    task automatic xfer(input logic [47:0] tx, input int n, output logic [47:0] rx);
        rx     = '0;
        oe_ok  = 1'b1;
        o_cs_n = 1'b0;
        o_si   = tx[n-1];
        #120;
        for (int i = n - 1; i >= 0; i--) begin
            o_sclk = 1'b1;
            #8;
            rx     = {rx[46:0], i_so};
            oe_ok  = oe_ok & ~i_so_oe_n;
            o_sclk = 1'b0;
            #1;
            // Past the last bit the line is not held, so it flips
            o_si = (i > 0) ? tx[i-1] : ~o_si;
            #6;
        end
        #60;
        o_cs_n = 1'b1;
        #60;
    endtask : xfer

    // Clock and data activity while deselected
    task automatic noise(input int n);
        repeat (n) begin
            o_sclk = 1'b1;
            o_si   = ~o_si;
            #7;
            o_sclk = 1'b0;
            #8;
        end
    endtask : noise
endmodule : smx_host

/* File: tb/testbench.sv */
`timescale 1ns/1ns

module testbench;
    import smx_pkg::*;

    logic        i_clk;
    logic        i_rst_n;
    logic        sclk;
    logic        cs_n;
    logic        si;
    logic        so;
    logic        so_oe_n;
    logic        so_line;
    logic        int_out;
    logic        int_oe_n;
    logic        int_wire;
    logic        therm;
    logic        int_en;
    logic        sleep;
    logic        wake;
    logic        wet;
    logic        scan;
    logic        itmr;
    smx_sw_t     sw;
    smx_sw_t     swa;
    smx_cmd_t    cmd;
    smx_word_t   last_cmd;
    logic [47:0] rx;
    int          fails = 0;
    int          compares = 0;
    int          ncmd = 0;
    int          nwake = 0;
    int          run_w = 0;
    int          run_s = 0;
    int          wet_run = 0;
    int          scan_run = 0;
    int          gap = 0;
    int          gap_c = 0;
    int          n0;

    initial i_clk = 1'b0;
    always #2 i_clk = ~i_clk;

    // Floating output shows the inverse of so, which select high resets to zero, so it reads one; INT has a pull-up
    assign so_line  = so_oe_n ? ~so : so;
    assign int_wire = int_oe_n ? 1'b1 : int_out;

    smx_spi_slave #(
        .WET_CYC        (20),
        .SCAN_ON_CYC    (10),
        .SCAN_PERIOD_CYC(30),
        .INT_PERIOD_CYC (40)
    ) dut (
        .i_clk          (i_clk),
        .i_rst_n        (i_rst_n),
        .i_sclk         (sclk),
        .i_cs_n         (cs_n),
        .i_si           (si),
        .o_so           (so),
        .o_so_oe_n      (so_oe_n),
        .i_int_in       (int_wire),
        .o_int_out      (int_out),
        .o_int_oe_n     (int_oe_n),
        .i_sw_closed    (sw),
        .i_therm        (therm),
        .i_int_en       (int_en),
        .i_sleep        (sleep),
        .o_cmd          (cmd),
        .o_wake         (wake),
        .o_wet_pulse    (wet),
        .o_scan_active  (scan),
        .o_int_timer_exp(itmr)
    );

    smx_host host (
        .o_sclk   (sclk),
        .o_cs_n   (cs_n),
        .o_si     (si),
        .i_so     (so_line),
        .i_so_oe_n(so_oe_n)
    );

    always @(posedge i_clk) begin
        if (cmd.valid === 1'b1) begin
            ncmd++;
            last_cmd = cmd.word;
        end
        if (wake === 1'b1) nwake++;
        if (wet === 1'b1) run_w++;
        else if (run_w > 0) begin
            wet_run = run_w;
            run_w   = 0;
        end
        if (scan === 1'b1) run_s++;
        else if (run_s > 0) begin
            scan_run = run_s;
            run_s    = 0;
        end
        gap_c++;
        if (itmr === 1'b1) begin
            gap   = gap_c;
            gap_c = 0;
        end
    end

    task automatic conclude();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : cyc

    task automatic wait_int(input logic exp);
        int k;
        k = 0;
        while (int_oe_n !== exp && k < 20) begin
            cyc(1);
            k++;
        end
        chk(int_oe_n, exp);
        if (int_oe_n !== exp) conclude();
    endtask : wait_int

    // Status snapshot, select-rise commit and fresh data afterwards
    task automatic t_frame();
        swa   = 22'h2A5C3F;
        sw    = swa;
        therm = 1'b1;
        cyc(10);
        n0 = ncmd;
        fork
            host.xfer(48'hA5C3E1, 24, rx);
            begin
                cyc(60);
                sw = ~swa;
                chk(ncmd, n0);
            end
        join
        chk(rx[23:0], {2'b01, swa});
        chk(host.oe_ok, 1'b1);
        cyc(10);
        chk(so_oe_n, 1'b1);
        chk(ncmd, n0 + 1);
        chk(last_cmd, 24'hA5C3E1);
        chk(nwake, 0);
        host.xfer(48'h123456ABCDEF, 48, rx);
        cyc(10);
        chk(rx[47:24], {2'b01, ~swa});
        chk(rx[23:0], 24'h123456);
        chk(last_cmd, 24'hABCDEF);
    endtask : t_frame

    // Deselected activity and a short frame both commit nothing
    task automatic t_refuse();
        n0 = ncmd;
        host.noise(12);
        cyc(10);
        chk(so_oe_n, 1'b1);
        host.xfer(48'h7FFFFF, 23, rx);
        cyc(10);
        chk(ncmd, n0);
    endtask : t_refuse

    // Interrupt held over a frame with a change, cleared by a clean one
    task automatic t_int();
        int_en = 1'b1;
        sw     = swa;
        wait_int(1'b0);
        fork
            host.xfer(48'h000001, 24, rx);
            begin
                cyc(60);
                sw = ~swa;
            end
        join
        chk(rx[23], 1'b1);
        cyc(10);
        chk(int_oe_n, 1'b0);
        chk(int_wire, 1'b0);
        host.xfer(48'h000002, 24, rx);
        wait_int(1'b1);
        int_en = 1'b0;
        sw     = swa;
        cyc(40);
        chk(int_oe_n, 1'b1);
        chk(wet_run, 20);
    endtask : t_int

    // Wake request and sleep timers
    task automatic t_sleep();
        sleep = 1'b1;
        cyc(2);
        n0 = nwake;
        // Status of a waking frame is not trusted, so rx is dropped
        host.xfer(48'h00000F, 24, rx);
        cyc(10);
        chk(nwake, n0 + 1);
        cyc(200);
        chk(scan_run, 10);
        chk(gap, 41);
    endtask : t_sleep

    initial begin
        i_rst_n = 1'b0;
        sw      = '0;
        therm   = 1'b0;
        int_en  = 1'b0;
        sleep   = 1'b0;
        repeat (2) @(posedge i_clk);
        #1;
        i_rst_n = 1'b1;
        cyc(8);
        chk(so_oe_n, 1'b1);
        chk(int_oe_n, 1'b1);
        chk(cmd, '0);
        t_frame();
        t_refuse();
        t_int();
        t_sleep();
        conclude();
    end
endmodule : testbench
